// [inc/fpi_pkg.sv]
package fpi_pkg;
  // cpu map: array occupies the top 16 KB, control register in the i/o page
  localparam logic [15:0] FPI_ARRAY_BASE = 16'hC000;
  localparam int FPI_ARRAY_BYTES = 16384;
  localparam int FPI_OFS_W = 14;
  localparam logic [15:0] FPI_CTRL_ADDR = 16'h0079;
  // control/status field positions and reset values
  localparam int FPI_BIT_IRQ_EN = 7;
  localparam int FPI_BIT_IRQ_FLAG = 6;
  localparam int FPI_BIT_WR_EN = 5;
  localparam int FPI_BIT_READY = 4;
  localparam logic FPI_IRQ_EN_RST = 1'b0;
  localparam logic FPI_IRQ_FLAG_RST = 1'b0;
  localparam logic FPI_WR_EN_RST = 1'b0;
  // command cycle addresses (low 12 offset bits) and command bytes
  localparam logic [11:0] FPI_UNLOCK_A1 = 12'h555;
  localparam logic [11:0] FPI_UNLOCK_A2 = 12'h2AA;
  localparam logic [7:0] FPI_CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] FPI_CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] FPI_CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] FPI_CMD_ERASE = 8'h80;
  localparam logic [7:0] FPI_CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] FPI_CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] FPI_CMD_RESET = 8'hF0;
  localparam logic [7:0] FPI_ERASED_BYTE = 8'hFF;
  // sectors are 4 KB, selected by the top two offset bits
  localparam int FPI_SECTOR_W = 12;
  // read protection byte
  localparam logic [13:0] FPI_PROTECT_OFS = 14'h3FFC;
  localparam logic [7:0] FPI_PROTECT_CODE = 8'h01;
  // embedded byte program time
  localparam int FPI_CLK_MHZ = 40;
  localparam int FPI_PROG_TIME_US = 16;
  localparam int FPI_PROG_CYCLES = FPI_PROG_TIME_US * FPI_CLK_MHZ;
  localparam int FPI_CNT_W = 10;
  // one-hot sequencer states
  typedef enum logic [8:0] {
    FPI_ST_IDLE = 9'b000000001,
    FPI_ST_UNLK1 = 9'b000000010,
    FPI_ST_UNLK2 = 9'b000000100,
    FPI_ST_PGM_DATA = 9'b000001000,
    FPI_ST_ERS_SETUP = 9'b000010000,
    FPI_ST_ERS_UNLK = 9'b000100000,
    FPI_ST_ERS_CMD = 9'b001000000,
    FPI_ST_PGM_BUSY = 9'b010000000,
    FPI_ST_ERS_BUSY = 9'b100000000
  } fpi_state_type;
endpackage

// [verilog/fpi_flash_if.sv]
`timescale 1ns/1ps
module fpi_flash_if
  import fpi_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  output logic [7:0] cpu_rdata,
  output logic flash_irq,
  input wire logic [15:0] prog_addr,
  input wire logic prog_rd,
  output logic [7:0] prog_rdata,
  output logic prog_refused
);

  // address decode shared by the cpu and the external programmer port
  function automatic logic in_array(input logic [15:0] a);
    in_array = (a >= FPI_ARRAY_BASE);
  endfunction
  function automatic logic [FPI_OFS_W-1:0] to_ofs(input logic [15:0] a);
    to_ofs = a[FPI_OFS_W-1:0];
  endfunction
  // reset released through two flops
  logic rst_meta_r;
  logic rst_sync_n;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // the array itself; no reset, contents survive like real cells
  logic [7:0] mem [0:FPI_ARRAY_BYTES-1];
  logic mem_we;
  logic [FPI_OFS_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end
  fpi_state_type state_r, state_nxt;
  logic [FPI_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [FPI_OFS_W-1:0] op_addr_r, op_addr_nxt;
  logic [FPI_OFS_W-1:0] last_r, last_nxt;
  logic [7:0] op_data_r, op_data_nxt;
  logic irq_en_r, irq_en_nxt;
  logic irq_flag_r, irq_flag_nxt;
  logic wr_en_r, wr_en_nxt;
  logic toggle_r, toggle_nxt;
  logic [7:0] cpu_rdata_r, cpu_rdata_nxt;
  logic [7:0] prog_rdata_r, prog_rdata_nxt;
  logic prog_refused_r, prog_refused_nxt;
  logic busy;
  logic done;
  logic wr_cmd;
  logic arr_rd;
  logic ctl_wr;
  logic protect_on;
  logic [FPI_OFS_W-1:0] cpu_ofs;
  logic [7:0] cpu_mem_q;
  logic [7:0] prog_mem_q;
  logic [7:0] poll_byte;
  logic [7:0] status_byte;
  assign cpu_ofs = to_ofs(cpu_addr);
  assign cpu_mem_q = mem[cpu_ofs];
  assign prog_mem_q = mem[to_ofs(prog_addr)];
  assign busy = (state_r == FPI_ST_PGM_BUSY) || (state_r == FPI_ST_ERS_BUSY);
  // only the cpu can start an operation, and only with write enable set
  assign wr_cmd = cpu_wr && in_array(cpu_addr) && wr_en_r;
  assign arr_rd = cpu_rd && in_array(cpu_addr);
  assign ctl_wr = cpu_wr && (cpu_addr == FPI_CTRL_ADDR);
  assign protect_on = (mem[FPI_PROTECT_OFS] == FPI_PROTECT_CODE);
  // polling: bit 7 is the complement of the target, 0 while erasing
  assign poll_byte = {(state_r == FPI_ST_PGM_BUSY) ? ~op_data_r[7] : 1'b0,
                      toggle_r, 6'h00};
  assign status_byte = {irq_en_r, irq_flag_r, wr_en_r, ~busy, 4'h0};

  // command sequencer: unlock pairs, then program or erase
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    op_addr_nxt = op_addr_r;
    last_nxt = last_r;
    op_data_nxt = op_data_r;
    mem_we = 1'b0;
    mem_wa = op_addr_r;
    mem_wd = FPI_ERASED_BYTE;
    done = 1'b0;
    case (state_r)
      FPI_ST_IDLE: begin
        if (wr_cmd && cpu_wdata == FPI_CMD_UNLOCK1 && cpu_ofs[11:0] == FPI_UNLOCK_A1) begin
          state_nxt = FPI_ST_UNLK1;
        end
      end
      FPI_ST_UNLK1, FPI_ST_ERS_SETUP: begin
        // a wrong cycle drops the sequence back to idle
        if (wr_cmd) begin
          if (state_r == FPI_ST_UNLK1 && cpu_wdata == FPI_CMD_UNLOCK2 &&
              cpu_ofs[11:0] == FPI_UNLOCK_A2) begin
            state_nxt = FPI_ST_UNLK2;
          end else if (state_r == FPI_ST_ERS_SETUP && cpu_wdata == FPI_CMD_UNLOCK1 &&
                       cpu_ofs[11:0] == FPI_UNLOCK_A1) begin
            state_nxt = FPI_ST_ERS_UNLK;
          end else begin
            state_nxt = FPI_ST_IDLE;
          end
        end
      end
      FPI_ST_UNLK2: begin
        if (wr_cmd) begin
          if (cpu_wdata == FPI_CMD_PROGRAM) begin
            state_nxt = FPI_ST_PGM_DATA;
          end else if (cpu_wdata == FPI_CMD_ERASE) begin
            state_nxt = FPI_ST_ERS_SETUP;
          end else begin
            state_nxt = FPI_ST_IDLE;
          end
        end
      end
      FPI_ST_PGM_DATA: begin
        if (wr_cmd) begin
          if (cpu_wdata == FPI_CMD_RESET) begin
            state_nxt = FPI_ST_IDLE;
          end else begin
            op_addr_nxt = cpu_ofs;
            op_data_nxt = cpu_wdata;
            cnt_nxt = FPI_CNT_W'(FPI_PROG_CYCLES - 1);
            state_nxt = FPI_ST_PGM_BUSY;
          end
        end
      end
      FPI_ST_ERS_UNLK: begin
        if (wr_cmd) begin
          if (cpu_wdata == FPI_CMD_UNLOCK2 && cpu_ofs[11:0] == FPI_UNLOCK_A2) begin
            state_nxt = FPI_ST_ERS_CMD;
          end else begin
            state_nxt = FPI_ST_IDLE;
          end
        end
      end
      FPI_ST_ERS_CMD: begin
        if (wr_cmd) begin
          state_nxt = FPI_ST_IDLE;
          if (cpu_wdata == FPI_CMD_CHIP_ERASE) begin
            op_addr_nxt = '0;
            last_nxt = '1;
            state_nxt = FPI_ST_ERS_BUSY;
          end else if (cpu_wdata == FPI_CMD_SECTOR_ERASE) begin
            op_addr_nxt = {cpu_ofs[FPI_OFS_W-1:FPI_SECTOR_W], {FPI_SECTOR_W{1'b0}}};
            last_nxt = {cpu_ofs[FPI_OFS_W-1:FPI_SECTOR_W], {FPI_SECTOR_W{1'b1}}};
            state_nxt = FPI_ST_ERS_BUSY;
          end
        end
      end
      FPI_ST_PGM_BUSY: begin
        // cells only go from 1 to 0, so the new byte is anded in
        if (cnt_r == '0) begin
          mem_we = 1'b1;
          mem_wd = mem[op_addr_r] & op_data_r;
          done = 1'b1;
          state_nxt = FPI_ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      FPI_ST_ERS_BUSY: begin
        // one byte per cycle; erase time is the sweep itself
        mem_we = 1'b1;
        op_addr_nxt = op_addr_r + 1'b1;
        if (op_addr_r == last_r) begin
          done = 1'b1;
          state_nxt = FPI_ST_IDLE;
        end
      end
      default: begin
        state_nxt = FPI_ST_IDLE;
      end
    endcase
    // reset command aborts any unfinished sequence, never a busy operation
    if (!busy && wr_cmd && cpu_wdata == FPI_CMD_RESET) begin
      state_nxt = FPI_ST_IDLE;
    end
  end

  // control/status and read paths
  always_comb begin
    irq_en_nxt = irq_en_r;
    wr_en_nxt = wr_en_r;
    irq_flag_nxt = irq_flag_r;
    toggle_nxt = toggle_r;
    cpu_rdata_nxt = cpu_rdata_r;
    prog_rdata_nxt = prog_rdata_r;
    prog_refused_nxt = 1'b0;
    if (ctl_wr) begin
      irq_en_nxt = cpu_wdata[FPI_BIT_IRQ_EN];
      wr_en_nxt = cpu_wdata[FPI_BIT_WR_EN];
      if (!cpu_wdata[FPI_BIT_IRQ_FLAG]) begin
        irq_flag_nxt = 1'b0;
      end
    end
    // completion set wins over a clear in the same cycle
    if (done) begin
      irq_flag_nxt = 1'b1;
    end
    if (cpu_rd) begin
      if (cpu_addr == FPI_CTRL_ADDR) begin
        cpu_rdata_nxt = status_byte;
      end else if (arr_rd && busy) begin
        cpu_rdata_nxt = poll_byte;
        toggle_nxt = ~toggle_r;
      end else if (arr_rd) begin
        cpu_rdata_nxt = cpu_mem_q;
      end else begin
        cpu_rdata_nxt = 8'h00;
      end
    end
    // programmer port uses cpu addresses; protection hides all data
    if (prog_rd && in_array(prog_addr)) begin
      if (protect_on) begin
        prog_rdata_nxt = 8'h00;
        prog_refused_nxt = 1'b1;
      end else begin
        prog_rdata_nxt = prog_mem_q;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r <= FPI_ST_IDLE;
      cnt_r <= '0;
      op_addr_r <= '0;
      last_r <= '0;
      op_data_r <= 8'h00;
      irq_en_r <= FPI_IRQ_EN_RST;
      irq_flag_r <= FPI_IRQ_FLAG_RST;
      wr_en_r <= FPI_WR_EN_RST;
      toggle_r <= 1'b0;
      cpu_rdata_r <= 8'h00;
      prog_rdata_r <= 8'h00;
      prog_refused_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      op_addr_r <= op_addr_nxt;
      last_r <= last_nxt;
      op_data_r <= op_data_nxt;
      irq_en_r <= irq_en_nxt;
      irq_flag_r <= irq_flag_nxt;
      wr_en_r <= wr_en_nxt;
      toggle_r <= toggle_nxt;
      cpu_rdata_r <= cpu_rdata_nxt;
      prog_rdata_r <= prog_rdata_nxt;
      prog_refused_r <= prog_refused_nxt;
    end
  end
  assign cpu_rdata = cpu_rdata_r;
  assign prog_rdata = prog_rdata_r;
  assign prog_refused = prog_refused_r;
  assign flash_irq = irq_flag_r && irq_en_r;
  // all checks live in the one clock domain, idle while the synced reset is low
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_sync_n);
  property p_rom_read;
    arr_rd && !busy |=> cpu_rdata == $past(cpu_mem_q);
  endproperty
  a_rom_read: assert property (p_rom_read) else $error("array read data wrong");
  property p_poll_bit;
    arr_rd && state_r == FPI_ST_PGM_BUSY |=> cpu_rdata[7] == ~$past(op_data_r[7]);
  endproperty
  a_poll_bit: assert property (p_poll_bit) else $error("polling bit wrong");
  // polls come with an idle cycle between them, so compare answers two cycles apart
  property p_toggle;
    (arr_rd && busy) ##1 !cpu_rd ##1 (arr_rd && busy) |=>
      cpu_rdata[6] != $past(cpu_rdata[6], 2);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle bit did not toggle");
  property p_busy_hide;
    arr_rd && busy |=> cpu_rdata[5:0] == 6'h00;
  endproperty
  a_busy_hide: assert property (p_busy_hide) else $error("contents leaked while busy");
  property p_ready_read;
    cpu_rd && cpu_addr == FPI_CTRL_ADDR |=> cpu_rdata[FPI_BIT_READY] == !$past(busy);
  endproperty
  a_ready_read: assert property (p_ready_read) else $error("ready bit wrong");
  property p_flag_on_done;
    $fell(busy) |-> irq_flag_r && $past(done);
  endproperty
  a_flag_on_done: assert property (p_flag_on_done) else $error("flag not set on done");
  property p_irq_out;
    done && irq_en_r && !ctl_wr |=> flash_irq;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq not raised");
  property p_we_block;
    state_r == FPI_ST_IDLE && cpu_wr && in_array(cpu_addr) && !wr_en_r |=> state_r == FPI_ST_IDLE;
  endproperty
  a_we_block: assert property (p_we_block) else $error("command taken without enable");
  property p_flag_clear;
    ctl_wr && !cpu_wdata[FPI_BIT_IRQ_FLAG] && !done |=> !irq_flag_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
  property p_protect;
    prog_rd && in_array(prog_addr) && protect_on |=> prog_refused && prog_rdata == 8'h00;
  endproperty
  a_protect: assert property (p_protect) else $error("protected read served");
  property p_unprotect;
    prog_rd && in_array(prog_addr) && !protect_on |=>
      !prog_refused && prog_rdata == $past(prog_mem_q);
  endproperty
  a_unprotect: assert property (p_unprotect) else $error("programmer read wrong");
  property p_pgm_hold;
    state_r == FPI_ST_PGM_DATA && wr_cmd && cpu_wdata != FPI_CMD_RESET |=> busy [*8];
  endproperty
  a_pgm_hold: assert property (p_pgm_hold) else $error("program ended early");
  c_pgm_done: cover property (state_r == FPI_ST_PGM_BUSY ##1 state_r == FPI_ST_IDLE);
  c_ers_done: cover property (state_r == FPI_ST_ERS_BUSY ##1 state_r == FPI_ST_IDLE);
  c_refused: cover property (prog_refused);
  c_irq: cover property ($rose(flash_irq));
endmodule

// [dv/fpi_cpu_model.sv]
`timescale 1ns/1ps
// cpu side of the bus: one strobe per access, lines moved off the last value when released
module fpi_cpu_model
  import fpi_pkg::*;
(
  input wire logic clock,
  output logic [15:0] cpu_addr,
  output logic [7:0] cpu_wdata,
  output logic cpu_rd,
  output logic cpu_wr,
  input wire logic [7:0] cpu_rdata
);
  initial begin
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
  end

  // single write, taken at the second edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clock);
    cpu_wr <= 1'b0;
    cpu_addr <= ~a; // released lines must not look valid
    cpu_wdata <= ~d;
  endtask

  // single read, data registered at the taking edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clock);
    cpu_rd <= 1'b0;
    cpu_addr <= ~a;
    #1;
    d = cpu_rdata;
  endtask

  // two unlock cycles shared by every command
  task automatic unlock();
    wr(FPI_ARRAY_BASE | 16'(FPI_UNLOCK_A1), FPI_CMD_UNLOCK1);
    wr(FPI_ARRAY_BASE | 16'(FPI_UNLOCK_A2), FPI_CMD_UNLOCK2);
  endtask

  task automatic prog_byte(input logic [15:0] a, input logic [7:0] d);
    unlock();
    wr(FPI_ARRAY_BASE, FPI_CMD_PROGRAM);
    wr(a, d);
  endtask

  task automatic erase(input logic [15:0] a, input logic [7:0] cmd);
    unlock();
    wr(FPI_ARRAY_BASE, FPI_CMD_ERASE);
    unlock();
    wr(a, cmd);
  endtask
endmodule

// [dv/flash_program_interface_bench.sv]
`timescale 1ns/1ps
module flash_program_interface_bench;
  import fpi_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic cpu_rd;
  logic cpu_wr;
  logic [7:0] cpu_rdata;
  logic flash_irq;
  logic [15:0] prog_addr = 16'h0000;
  logic prog_rd = 1'b0;
  logic [7:0] prog_rdata;
  logic prog_refused;
  int n_errors = 0;
  int num_checks = 0;
  logic [7:0] mem [int]; // bytes written so far; absent means erased
  logic [7:0] v;
  logic [7:0] v2;
  logic [15:0] a;
  logic [7:0] d;
  logic r;

  always #12.5 clock = ~clock;

  fpi_flash_if uut (.clock(clock), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_rdata(cpu_rdata), .flash_irq(flash_irq),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata),
    .prog_refused(prog_refused));
  fpi_cpu_model u_cpu (.clock(clock), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_rdata(cpu_rdata));

  function automatic logic [7:0] exp_byte(input logic [15:0] adr);
    return mem.exists(adr) ? mem[adr] : FPI_ERASED_BYTE;
  endfunction

  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk1(input string what, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // external programmer read, answer one cycle later
  task automatic prd(input logic [15:0] adr, output logic [7:0] dat, output logic rf);
    @(posedge clock);
    prog_addr <= adr;
    prog_rd <= 1'b1;
    @(posedge clock);
    prog_rd <= 1'b0;
    prog_addr <= ~adr;
    #1;
    dat = prog_rdata;
    rf = prog_refused;
  endtask

  // poll ready with a bound, then check and clear the completion flag
  task automatic wait_done();
    v = 8'h00;
    for (int i = 0; i < 20000 && v[FPI_BIT_READY] !== 1'b1; i++) begin
      u_cpu.rd(FPI_CTRL_ADDR, v);
    end
    chk8("status done", 8'hF0, v);
    chk1("irq set", 1'b1, flash_irq);
    u_cpu.wr(FPI_CTRL_ADDR, 8'hA0);
    u_cpu.rd(FPI_CTRL_ADDR, v);
    chk8("status cleared", 8'hB0, v);
    chk1("irq clear", 1'b0, flash_irq);
  endtask

  task automatic check_all();
    foreach (mem[k]) begin
      u_cpu.rd(16'(k), v);
      chk8("cpu byte", mem[k], v);
      prd(16'(k), v, r);
      chk8("prog byte", mem[k], v);
      chk1("not refused", 1'b0, r);
    end
  endtask

  initial begin
    void'($urandom(32'h4D6A7AFB));
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    u_cpu.rd(FPI_CTRL_ADDR, v);
    chk8("status reset", 8'h10, v);
    u_cpu.rd(16'h0000, v);
    chk8("unmapped", 8'h00, v);
    u_cpu.wr(FPI_CTRL_ADDR, 8'hFF);
    u_cpu.rd(FPI_CTRL_ADDR, v);
    chk8("status rw", 8'hB0, v);
    // array powers up unknown, so erase it whole first
    u_cpu.erase(FPI_ARRAY_BASE | 16'(FPI_UNLOCK_A1), FPI_CMD_CHIP_ERASE);
    u_cpu.rd(16'hE000, v);
    chk1("erase poll", 1'b0, v[7]);
    wait_done();
    // top byte and a sector-0 byte first, then random places
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 16'hFFFF : (i == 1) ? 16'hC123 : {2'b11, 14'($urandom_range(0, 16379))};
      d = 8'($urandom);
      if (d == FPI_CMD_RESET) begin
        d = 8'h0F; // the reset byte would abort the program instead of starting it
      end
      u_cpu.prog_byte(a, d);
      u_cpu.rd(a, v);
      u_cpu.rd(a, v2);
      chk8("busy poll", {~d[7], 7'h00}, {v[7], 1'b0, v[5:0]});
      chk1("toggle", ~v[6], v2[6]);
      u_cpu.rd(FPI_CTRL_ADDR, v);
      chk8("status busy", 8'hA0, v);
      wait_done();
      mem[a] = exp_byte(a) & d;
    end
    // array commands with write enable off are ignored
    u_cpu.wr(FPI_CTRL_ADDR, 8'h80);
    u_cpu.prog_byte(16'hC001, 8'h00);
    u_cpu.rd(FPI_CTRL_ADDR, v);
    chk8("we off", 8'h90, v);
    u_cpu.wr(FPI_CTRL_ADDR, 8'hA0);
    u_cpu.unlock();
    u_cpu.wr(FPI_ARRAY_BASE, FPI_CMD_PROGRAM);
    u_cpu.wr(FPI_ARRAY_BASE, FPI_CMD_RESET);
    u_cpu.wr(16'hC001, 8'h00);
    u_cpu.rd(FPI_CTRL_ADDR, v);
    chk8("aborted", 8'hB0, v);
    u_cpu.rd(16'hC001, v);
    chk8("c001 kept", exp_byte(16'hC001), v);
    u_cpu.erase(16'hC800, FPI_CMD_SECTOR_ERASE);
    wait_done();
    foreach (mem[k]) begin
      if (k < 32'hD000) mem[k] = FPI_ERASED_BYTE;
    end
    check_all();
    // protection code goes in last, after everything is verified
    u_cpu.prog_byte(16'hFFFC, FPI_PROTECT_CODE);
    wait_done();
    u_cpu.rd(16'hFFFC, v);
    chk8("code", FPI_PROTECT_CODE, v);
    prd(16'hFFFF, v, r);
    chk8("locked data", 8'h00, v);
    chk1("refused", 1'b1, r);
    conclude();
  end

  // watchdog sized well above erase sweeps plus programs
  initial begin
    repeat (50000) @(posedge clock);
    n_errors++;
    conclude();
  end
endmodule
